// file: dv/odmc_load_model.sv
`timescale 1ns/1ns
// Loads on the eight outputs, with a short or a hot spot per channel on demand
module odmc_load_model (
    input wire logic [7:0] driver_output,
    input wire logic [7:0] short_ch,
    input wire logic [7:0] hot_ch,
    output logic [7:0] overload,
    output logic [7:0] overtemp
);
    // A short only draws current while its channel conducts
    assign overload = driver_output & short_ch;
    assign overtemp = hot_ch;
endmodule

// file: dv/odmc_top_test.sv
`timescale 1ns/1ns
module odmc_top_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic en = 1'b1;
    logic limp_home_input = 1'b0;
    logic logic_supply_ok = 1'b1;
    logic analog_supply_ok = 1'b1;
    logic [3:0] par_in = 4'h0;
    logic [7:0] short_ch = 8'h00;
    logic [7:0] hot_ch = 8'h00;
    logic [7:0] overload;
    logic [7:0] overtemp;
    logic [7:0] driver_output;
    logic [7:0] diag_current_en;
    logic undervoltage_lockout_mode;
    logic lowest_quiescent_state;
    logic reduced_quiescent;
    logic [31:0] rdat;
    logic rerr;
    int fails = 0;
    int total_checks = 0;

    always #10 clk_sys = ~clk_sys;

    odmc_top i_odmc_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .en(en), .limp_home_input(limp_home_input),
        .logic_supply_ok(logic_supply_ok), .analog_supply_ok(analog_supply_ok),
        .par_in(par_in), .overload(overload), .overtemp(overtemp),
        .driver_output(driver_output), .diag_current_en(diag_current_en),
        .undervoltage_lockout_mode(undervoltage_lockout_mode),
        .lowest_quiescent_state(lowest_quiescent_state),
        .reduced_quiescent(reduced_quiescent));

    odmc_load_model i_odmc_load_model (.driver_output(driver_output), .short_ch(short_ch),
        .hot_ch(hot_ch), .overload(overload), .overtemp(overtemp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Holds the request until pready is seen; the idle cycle after keeps drives apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(6);
        rst_n <= 1'b1;
        wait_cyc(10);
        rdm(odmc_pkg::ADDR_CMD, 32'hFFFF, 32'hFFFF);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h0);
        rdm(odmc_pkg::ADDR_MODE, 32'h1F, 32'h0F);
        chk({24'h0, diag_current_en}, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, odmc_pkg::ADDR_STATUS, 32'hFFFF);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h0);
        $display("reset and map test done");
        // Ch1 on, ch2 and ch6 parallel, ch3 standby, the rest off
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C6);
        rdm(odmc_pkg::ADDR_MODE, 32'h1F, 32'h03);
        par_in <= 4'h2;
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h23);
        chk({24'h0, diag_current_en & 8'hDC}, 32'hD8);
        par_in <= 4'h1;
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h01);
        $display("mode decode test done");
        short_ch <= 8'h01;
        wait_cyc(100);
        short_ch <= 8'h00;
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h01);
        short_ch <= 8'h01;
        wait_cyc(770);
        chk({24'h0, driver_output}, 32'h00);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h1);
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C6);
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h00);
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C4);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h0);
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C6);
        wait_cyc(770);
        chk({24'h0, driver_output}, 32'h00);
        short_ch <= 8'h00;
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C4);
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hF7C6);
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h01);
        hot_ch <= 8'h01;
        wait_cyc(8);
        chk({24'h0, driver_output}, 32'h00);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h2);
        hot_ch <= 8'h00;
        $display("overload test done");
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'h0000);
        wait_cyc(4);
        chk({31'h0, reduced_quiescent}, 32'h1);
        chk({24'h0, diag_current_en}, 32'h0);
        rdm(odmc_pkg::ADDR_MODE, 32'h13, 32'h13);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h0);
        en <= 1'b0;
        wait_cyc(8);
        chk({31'h0, lowest_quiescent_state}, 32'h1);
        rdm(odmc_pkg::ADDR_MODE, 32'h3, 32'h1);
        en <= 1'b1;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h7, 32'h7);
        rdm(odmc_pkg::ADDR_CMD, 32'hFFFF, 32'hFFFF);
        chk({24'h0, diag_current_en}, 32'hFF);
        $display("standby and enable test done");
        limp_home_input <= 1'b1;
        par_in <= 4'hA;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h3, 32'h2);
        chk({24'h0, driver_output}, 32'h0A);
        apb(1'b1, odmc_pkg::ADDR_CMD, 32'hAAAA);
        rdm(odmc_pkg::ADDR_CMD, 32'hFFFF, 32'hFFFF);
        logic_supply_ok <= 1'b0;
        wait_cyc(8);
        chk({31'h0, undervoltage_lockout_mode}, 32'h0);
        chk({24'h0, driver_output}, 32'h0A);
        logic_supply_ok <= 1'b1;
        short_ch <= 8'h02;
        wait_cyc(770);
        chk({24'h0, driver_output}, 32'h08);
        rdm(odmc_pkg::ADDR_STATUS, 32'hC, 32'h4);
        short_ch <= 8'h00;
        limp_home_input <= 1'b0;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h7, 32'h7);
        rdm(odmc_pkg::ADDR_STATUS, 32'hFFFF, 32'h0);
        chk({24'h0, diag_current_en}, 32'h0);
        $display("limp home test done");
        analog_supply_ok <= 1'b0;
        wait_cyc(8);
        chk({31'h0, undervoltage_lockout_mode}, 32'h1);
        chk({24'h0, driver_output}, 32'h00);
        limp_home_input <= 1'b1;
        analog_supply_ok <= 1'b1;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h3, 32'h2);
        chk({31'h0, undervoltage_lockout_mode}, 32'h0);
        // Limp exit with enable low, then a limp rise from the quiet state
        limp_home_input <= 1'b0;
        en <= 1'b0;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h3, 32'h1);
        chk({31'h0, lowest_quiescent_state}, 32'h1);
        limp_home_input <= 1'b1;
        wait_cyc(8);
        rdm(odmc_pkg::ADDR_MODE, 32'h3, 32'h2);
        chk({24'h0, driver_output}, 32'h0A);
        $display("lockout test done");
        tally_and_finish();
    end
endmodule

// file: hw/odmc_pkg.sv
package odmc_pkg;
    localparam int NCH = 8;
    localparam int CLK_NS = 20;
    // Overload shutdown filter, typical figure
    localparam int OL_DELAY_NS = 15000;
    localparam int OL_CYC = (OL_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int OL_W = $clog2(OL_CYC + 1);
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [15:0] CMD_RST = 16'hFFFF;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic FERR_RST = 1'b1;
    localparam int MODE_STATE_LSB = 0;
    localparam int MODE_FERR_BIT = 2;
    localparam int MODE_PWRUP_BIT = 3;
    localparam int MODE_GSTBY_BIT = 4;
    localparam logic [1:0] CMD_STBY = 2'h0;
    localparam logic [1:0] CMD_PAR = 2'h1;
    localparam logic [1:0] CMD_ON = 2'h2;
    localparam logic [1:0] CMD_OFF = 2'h3;

    typedef enum logic [1:0] {
        ST_LOCKOUT = 2'h0,
        ST_LOWQ = 2'h1,
        ST_RUN = 2'h3,
        ST_LIMP = 2'h2
    } odmc_state_e;

    typedef struct packed {
        logic en;
        logic limp_home_input;
        logic logic_supply_ok;
        logic analog_supply_ok;
        logic [3:0] par_in;
    } odmc_pins_s;
endpackage

// file: hw/odmc_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Filtered overload latches channel off
// - Overload seen at turn-on or later
// - Standby or power-on reset clears faults
// - Commands only after reset; enable rise reinitialises
// - Two-bit command per channel decoded
// - Standby is off, diagnostic off; all-standby reduced
// - Off mode: diagnostic per power-up variant
// - Reset: commands off, status zero, error set
// - Need both supplies; limp ignores logic supply
// - Power-up global off without diagnostic current
// - Lockout all off; limp wins at exit
// - Enable and limp low: lowest quiescent
// - Parallel input drives outputs i and i+4
// - Channel commanded off leaves parallel control
// - Limp: outputs 1-4 follow pins, 5-8 off
// - Limp ignores commands, keeps fault reporting
// - Leaving limp resets registers, diagnostic off
// - Limp to global off sets error flag
// - Analog reset forces lockout and clears faults, also in limp
// - Enable rise leaves lowest quiescent state
// - Limp rise powers up into limp mode
// - Two command and two status bits each
// - Standby clears own channel; events clear all
module odmc_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic en,
    input wire logic limp_home_input,
    input wire logic logic_supply_ok,
    input wire logic analog_supply_ok,
    input wire logic [3:0] par_in,
    input wire logic [7:0] overload,
    input wire logic [7:0] overtemp,
    output logic [7:0] driver_output,
    output logic [7:0] diag_current_en,
    output logic undervoltage_lockout_mode,
    output logic lowest_quiescent_state,
    output logic reduced_quiescent
);
    localparam int N = odmc_pkg::NCH;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    odmc_pkg::odmc_pins_s pin_s1_ff, pin_s2_ff, pin_prev_ff;
    logic [N-1:0] ol_s1_ff, ol_s2_ff, ot_s1_ff, ot_s2_ff;
    odmc_pkg::odmc_pins_s pin_raw;
    assign pin_raw = '{en, limp_home_input, logic_supply_ok, analog_supply_ok, par_in};

    always_ff @(posedge clk_sys) begin
        pin_s1_ff <= pin_raw;
        pin_s2_ff <= pin_s1_ff;
        pin_prev_ff <= pin_s2_ff;
        ol_s1_ff <= overload;
        ol_s2_ff <= ol_s1_ff;
        ot_s1_ff <= overtemp;
        ot_s2_ff <= ot_s1_ff;
    end

    wire en_s = pin_s2_ff.en;
    wire lhi_s = pin_s2_ff.limp_home_input;
    wire en_rise = en_s & ~pin_prev_ff.en;

    ////////////////////////////////////////////////////////////////////////
    // Global mode
    odmc_pkg::odmc_state_e st_ff, nxt_st;
    logic [15:0] cmd_ff, nxt_cmd;
    logic [15:0] stat_ff, nxt_stat;
    logic ferr_ff, nxt_ferr;
    logic pwrup_ff, nxt_pwrup;
    logic clr_all;

    // supply gating; logic supply ignored in limp
    wire sup_bad = ~pin_s2_ff.analog_supply_ok
        | (~pin_s2_ff.logic_supply_ok & st_ff != odmc_pkg::ST_LIMP);

    always_comb begin
        nxt_st = st_ff;
        clr_all = 1'b0;
        nxt_pwrup = pwrup_ff;
        case (st_ff)
            odmc_pkg::ST_LOCKOUT: begin
                if (!sup_bad) begin
                    clr_all = 1'b1;
                    if (lhi_s) begin
                        nxt_st = odmc_pkg::ST_LIMP;
                    end else if (en_s) begin
                        nxt_st = odmc_pkg::ST_RUN;
                        nxt_pwrup = 1'b1;
                    end else begin
                        nxt_st = odmc_pkg::ST_LOWQ;
                    end
                end
            end
            odmc_pkg::ST_LOWQ: begin
                // limp rise powers up into limp
                if (lhi_s) begin
                    nxt_st = odmc_pkg::ST_LIMP;
                    clr_all = 1'b1;
                end else if (en_rise) begin
                    // enable rise to global off, diagnostic on
                    nxt_st = odmc_pkg::ST_RUN;
                    nxt_pwrup = 1'b0;
                    clr_all = 1'b1;
                end
            end
            odmc_pkg::ST_RUN: begin
                if (lhi_s) begin
                    nxt_st = odmc_pkg::ST_LIMP;
                    clr_all = 1'b1;
                end else if (!en_s) begin
                    nxt_st = odmc_pkg::ST_LOWQ;
                    clr_all = 1'b1;
                end
            end
            odmc_pkg::ST_LIMP: begin
                if (!lhi_s) begin
                    clr_all = 1'b1;
                    nxt_pwrup = 1'b1;
                    nxt_st = en_s ? odmc_pkg::ST_RUN : odmc_pkg::ST_LOWQ;
                end
            end
            default: begin
                nxt_st = odmc_pkg::ST_LOCKOUT;
            end
        endcase
        if (sup_bad) begin
            nxt_st = odmc_pkg::ST_LOCKOUT;
            clr_all = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, data from flops
    wire setup = psel & ~penable;
    // Write lands on the access edge, when the master sees pready
    wire acc_done = psel & penable & pready;
    wire wr_cmd = acc_done & pwrite & paddr == odmc_pkg::ADDR_CMD;
    wire mapped = paddr == odmc_pkg::ADDR_CMD | paddr == odmc_pkg::ADDR_STATUS
        | paddr == odmc_pkg::ADDR_MODE;
    // commands taken only in run state, and not in the cycle it is left
    wire cmd_ok = wr_cmd & st_ff == odmc_pkg::ST_RUN & nxt_st == odmc_pkg::ST_RUN;
    logic [31:0] rd_mux;
    logic [31:0] mode_word;
    logic gstby;
    assign gstby = st_ff == odmc_pkg::ST_RUN & cmd_ff == 16'h0000;
    always_comb begin
        mode_word = 32'h0000_0000;
        mode_word[odmc_pkg::MODE_STATE_LSB +: 2] = st_ff;
        mode_word[odmc_pkg::MODE_FERR_BIT] = ferr_ff;
        mode_word[odmc_pkg::MODE_PWRUP_BIT] = pwrup_ff;
        mode_word[odmc_pkg::MODE_GSTBY_BIT] = gstby;
    end
    assign rd_mux = paddr == odmc_pkg::ADDR_CMD ? {16'h0000, cmd_ff}
        : paddr == odmc_pkg::ADDR_STATUS ? {16'h0000, stat_ff}
        : paddr == odmc_pkg::ADDR_MODE ? mode_word : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands, faults, drive
    logic [N-1:0][odmc_pkg::OL_W-1:0] ol_cnt_ff;
    logic [N-1:0] nxt_drv, nxt_diag, hit;

    // two bits each, channel i at 2i+1:2i
    function automatic logic [1:0] chcmd(input logic [15:0] c, input int i);
        chcmd = c[2*i +: 2];
    endfunction

    always_comb begin
        nxt_cmd = cmd_ff;
        nxt_stat = stat_ff;
        nxt_ferr = ferr_ff;
        if (cmd_ok) begin
            nxt_cmd = pwdata[15:0];
            nxt_ferr = 1'b0;
        end
        for (int i = 0; i < N; i++) begin
            // standby clears only its own channel
            if (chcmd(cmd_ff, i) == odmc_pkg::CMD_STBY) begin
                nxt_stat[2*i +: 2] = 2'h0;
            end
            // fault set; it never clears by itself
            if (hit[i]) begin
                nxt_stat[2*i] = 1'b1;
            end
            if (ot_s2_ff[i] & driver_output[i]) begin
                nxt_stat[2*i+1] = 1'b1;
            end
        end
        // reinitialise; error flag set on reentry
        if (clr_all) begin
            nxt_cmd = odmc_pkg::CMD_RST;
            nxt_stat = odmc_pkg::STATUS_RST;
            if (nxt_st == odmc_pkg::ST_RUN) begin
                nxt_ferr = 1'b1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            // latch once the filter delay has passed
            hit[i] = ol_s2_ff[i] & ol_cnt_ff[i] == odmc_pkg::OL_W'(odmc_pkg::OL_CYC - 1);
            nxt_drv[i] = 1'b0;
            nxt_diag[i] = 1'b0;
            if (st_ff == odmc_pkg::ST_RUN) begin
                case (chcmd(cmd_ff, i))
                    odmc_pkg::CMD_ON: nxt_drv[i] = 1'b1;
                    odmc_pkg::CMD_PAR: nxt_drv[i] = pin_s2_ff.par_in[i % 4];
                    // diagnostic only in the normal off variant
                    odmc_pkg::CMD_OFF: nxt_diag[i] = ~pwrup_ff;
                    default: nxt_drv[i] = 1'b0;
                endcase
            end else if (st_ff == odmc_pkg::ST_LIMP) begin
                // low half follows pins, high half off
                nxt_drv[i] = (i < 4) ? pin_s2_ff.par_in[i % 4] : 1'b0;
            end
            // latched channel stays off in every mode
            if (stat_ff[2*i] | stat_ff[2*i+1] | hit[i] | clr_all) begin
                nxt_drv[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= odmc_pkg::ST_LOCKOUT;
            cmd_ff <= odmc_pkg::CMD_RST;
            stat_ff <= odmc_pkg::STATUS_RST;
            ferr_ff <= odmc_pkg::FERR_RST;
            pwrup_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            cmd_ff <= nxt_cmd;
            stat_ff <= nxt_stat;
            ferr_ff <= nxt_ferr;
            // A real command ends the power-up variant of off mode
            pwrup_ff <= cmd_ok ? 1'b0 : nxt_pwrup;
        end
    end

    // count only while conducting, so both short cases match
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < N; i++) begin
            if (!rst_n || !(ol_s2_ff[i] & driver_output[i])) begin
                ol_cnt_ff[i] <= '0;
            end else if (!hit[i]) begin
                ol_cnt_ff[i] <= ol_cnt_ff[i] + odmc_pkg::OL_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            driver_output <= 8'h00;
            diag_current_en <= 8'h00;
            undervoltage_lockout_mode <= 1'b1;
            lowest_quiescent_state <= 1'b0;
            reduced_quiescent <= 1'b0;
        end else begin
            driver_output <= nxt_drv;
            diag_current_en <= nxt_diag;
            undervoltage_lockout_mode <= st_ff == odmc_pkg::ST_LOCKOUT;
            lowest_quiescent_state <= st_ff == odmc_pkg::ST_LOWQ;
            reduced_quiescent <= gstby;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ol_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        hit[0] |=> stat_ff[0] ##1 !driver_output[0];
    endproperty
    a_ol_latch: assert property (p_ol_latch) else $error("overload not latched");

    property p_ol_count;
        @(posedge clk_sys) disable iff (!rst_n)
        (ol_s2_ff[1] & driver_output[1] & !hit[1]) |=> ol_cnt_ff[1] == $past(ol_cnt_ff[1]) + 1;
    endproperty
    a_ol_count: assert property (p_ol_count) else $error("overload filter stuck");

    property p_stby_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        (cmd_ff[1:0] == 2'h0 & !hit[0]) |=> !stat_ff[0];
    endproperty
    a_stby_clr: assert property (p_stby_clr) else $error("standby kept fault");

    property p_limp_cmd;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_ff == odmc_pkg::ST_LIMP & lhi_s & !sup_bad) |=> $stable(cmd_ff);
    endproperty
    a_limp_cmd: assert property (p_limp_cmd) else $error("command taken in limp");

    property p_limp_hi;
        @(posedge clk_sys) disable iff (!rst_n)
        st_ff == odmc_pkg::ST_LIMP |=> driver_output[7:4] == 4'h0;
    endproperty
    a_limp_hi: assert property (p_limp_hi) else $error("limp upper half on");

    property p_lock_off;
        @(posedge clk_sys) disable iff (!rst_n)
        st_ff == odmc_pkg::ST_LOCKOUT |=> driver_output == 8'h00 & undervoltage_lockout_mode;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("output on in lockout");

    property p_limp_exit;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_ff == odmc_pkg::ST_LIMP ##1 st_ff == odmc_pkg::ST_RUN)
            |-> ferr_ff & pwrup_ff & cmd_ff == odmc_pkg::CMD_RST;
    endproperty
    a_limp_exit: assert property (p_limp_exit) else $error("limp exit not reset");

    property p_lowq;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_ff == odmc_pkg::ST_LOWQ & en_rise & !lhi_s & !sup_bad)
            |=> st_ff == odmc_pkg::ST_RUN ##1 !lowest_quiescent_state;
    endproperty
    a_lowq: assert property (p_lowq) else $error("enable rise ignored");

    property p_analog;
        @(posedge clk_sys) disable iff (!rst_n)
        !pin_s2_ff.analog_supply_ok |=> st_ff == odmc_pkg::ST_LOCKOUT;
    endproperty
    a_analog: assert property (p_analog) else $error("analog reset missed");
endmodule
